//--- shared/sfa_pkg.sv
package sfa_pkg;

	// Width of one demultiplexed word; the serial clock is divided by the same figure.
	localparam int unsigned BYTE_W = 8;

	// Serial clock period in picoseconds, one serial bit per cycle.
	localparam int unsigned SERIAL_PERIOD_PS = 8000;

	// Byte period in picoseconds and in serial clock cycles.
	localparam int unsigned BYTE_PERIOD_PS = SERIAL_PERIOD_PS * BYTE_W;
	localparam int unsigned BYTE_CYCLES = BYTE_PERIOD_PS / SERIAL_PERIOD_PS;

	// Frame pulse width in byte periods.
	localparam int unsigned FP_WIDTH_BYTES = 1;

	// Framing bytes, first serial bit in the most significant position.
	localparam logic [7:0] FRAME_A1 = 8'hF6;
	localparam logic [7:0] FRAME_A2 = 8'h28;

	// Number of aligned words kept for frame detection: four A1 and two A2.
	localparam int unsigned HIST_WORDS = 6;

	// Reset values.
	localparam logic [7:0] RST_WORD = 8'h00;
	localparam logic       RST_BIT  = 1'b0;

	// Recovery state.
	typedef enum logic [1:0] {
		SFA_ST_IDLE,
		SFA_ST_HUNT,
		SFA_ST_TRACK
	} sfa_state_t;

endpackage

//--- verilog/sfa_byte_div.sv
`timescale 1ns/1ps
module sfa_byte_div
	import sfa_pkg::*;
#(
	parameter int unsigned DIV = BYTE_CYCLES
) (
	// Clock and reset.
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	// Phase control.
	input  wire logic load_i,
	// Byte rate enables.
	output logic      stb_o,
	output logic      half_o
);

	localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] MID  = CW'(DIV / 2 - 1);

	logic [CW-1:0] cnt_r;

	// Refuse a divider that has no distinct middle and end.
	if (DIV < 4) begin : g_bad_div
		$error("sfa_byte_div: DIV must be at least 4");
	end

	// A load forces a word boundary now and restarts the count from zero.
	assign stb_o  = (cnt_r == LAST) | load_i;
	assign half_o = (cnt_r == MID) & ~load_i;

	// Divide the serial clock into byte periods.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r <= '0;
		end else if (stb_o) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + CW'(1);
		end
	end

endmodule

//--- verilog/sfa_align_demux.sv
`timescale 1ns/1ps
module sfa_align_demux
	import sfa_pkg::*;
#(
	parameter int unsigned WORD_W = BYTE_W
) (
	// Clock and reset.
	input  wire logic              clk_sys_i,
	input  wire logic              resetn_i,
	// Serial line, one bit per clock.
	input  wire logic              serial_data_in_i,
	// Frame control from the supervisor.
	input  wire logic              frame_hunt_trigger_n_i,
	input  wire logic              recovery_inhibit_i,
	// Parallel side.
	output logic [WORD_W-1:0]      parallel_data_out_o,
	output logic                   byte_clock_out_o,
	output logic                   parallel_data_valid_o,
	// Frame status.
	output logic                   frame_pulse_o,
	output logic                   recovery_active_o
);

	// The framing patterns are eight bits wide, so the word must be too.
	if (WORD_W != BYTE_W) begin : g_bad_width
		$error("sfa_align_demux: WORD_W must equal BYTE_W");
	end

	// Compare one word against a framing pattern.
	function automatic logic word_is(input logic [WORD_W-1:0] w, input logic [7:0] pat);
		word_is = (w == pat);
	endfunction

	sfa_state_t        state_r;
	sfa_state_t        state_nxt;
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] hist_r [HIST_WORDS-1];
	logic [WORD_W-1:0] word_r;
	logic              trig_n_r;
	logic              byte_clk_r;
	logic              valid_r;
	logic              fp_r;
	logic              active_r;
	logic              hunt_fall;
	logic              align_load;
	logic              byte_stb;
	logic              byte_half;
	logic              frame_hit;
	logic              full_frame;
	logic              word_a1_to_a2;

	// Byte rate enables from the divide-by-eight counter.
	sfa_byte_div #(
		.DIV    (BYTE_CYCLES)
	) u_div (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.load_i    (align_load),
		.stb_o     (byte_stb),
		.half_o    (byte_half)
	);

	// Serial bits enter at the bottom so the first bit ends up as the MSB.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_r <= RST_WORD;
		end else begin
			shift_r <= {shift_r[WORD_W-2:0], serial_data_in_i};
		end
	end

	// Remember the trigger level to find its falling edge.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			trig_n_r <= 1'b1;
		end else begin
			trig_n_r <= frame_hunt_trigger_n_i;
		end
	end

	assign hunt_fall = trig_n_r & ~frame_hunt_trigger_n_i;

	// A complete A1 in the shift register during a hunt fixes the byte phase.
	assign align_load = (state_r == SFA_ST_HUNT) && !hunt_fall && word_is(shift_r, FRAME_A1);

	// Aligned A1 A2 A2 ending in the word now on the outputs.
	assign frame_hit = word_is(hist_r[1], FRAME_A1) && word_is(hist_r[0], FRAME_A2)
		&& word_is(word_r, FRAME_A2);

	// Four A1 followed by two A2 on the outputs.
	assign full_frame = word_is(hist_r[4], FRAME_A1) && word_is(hist_r[3], FRAME_A1)
		&& word_is(hist_r[2], FRAME_A1) && frame_hit;

	// The output is about to move from an A1 word to an A2 word.
	assign word_a1_to_a2 = word_is(word_r, FRAME_A1) && word_is(shift_r, FRAME_A2);

	// Recovery state: idle, hunting for the first A1, tracking until the frame confirms.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SFA_ST_IDLE: begin
				state_nxt = SFA_ST_IDLE;
			end
			SFA_ST_HUNT: begin
				if (align_load) begin
					state_nxt = SFA_ST_TRACK;
				end
			end
			SFA_ST_TRACK: begin
				if (byte_stb && (frame_hit || full_frame)) begin
					state_nxt = SFA_ST_IDLE;
				end
			end
			default: begin
				state_nxt = SFA_ST_IDLE;
			end
		endcase
		// A new trigger edge overrides whatever the search was doing.
		if (hunt_fall) begin
			state_nxt = recovery_inhibit_i ? SFA_ST_IDLE : SFA_ST_HUNT;
		end
	end

	// Hold the recovery state.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= SFA_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Report whether recovery is armed.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			active_r <= RST_BIT;
		end else begin
			active_r <= (state_nxt != SFA_ST_IDLE);
		end
	end

	// Capture a word at every byte boundary.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			word_r <= RST_WORD;
		end else if (byte_stb) begin
			word_r <= shift_r;
		end
	end

	// Keep earlier words for frame detection; index 0 is the newest.
	for (genvar gi = 0; gi < HIST_WORDS - 1; gi++) begin : g_hist
		if (gi == 0) begin : g_head
			// The newest history word takes the word leaving the outputs.
			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					hist_r[gi] <= RST_WORD;
				end else if (byte_stb) begin
					hist_r[gi] <= word_r;
				end
			end
		end else begin : g_tail
			// Older words move one place back at each boundary, so no index runs below zero.
			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					hist_r[gi] <= RST_WORD;
				end else if (byte_stb) begin
					hist_r[gi] <= hist_r[gi-1];
				end
			end
		end
	end

	// Byte clock: high for the first half of each word period, rising with new data.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			byte_clk_r <= RST_BIT;
		end else if (byte_stb) begin
			byte_clk_r <= 1'b1;
		end else if (byte_half) begin
			byte_clk_r <= 1'b0;
		end
	end

	// Data is invalid from the trigger edge until the output moves from A1 to A2.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			valid_r <= RST_BIT;
		end else if (hunt_fall) begin
			valid_r <= 1'b0;
		end else if (byte_stb && word_a1_to_a2) begin
			valid_r <= 1'b1;
		end
	end

	// Frame pulse: decided once per word from the outputs alone, never from the trigger.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fp_r <= RST_BIT;
		end else if (byte_stb) begin
			fp_r <= frame_hit;
		end
	end

	// Drive the ports from their flip-flops.
	assign parallel_data_out_o   = word_r;
	assign byte_clock_out_o      = byte_clk_r;
	assign parallel_data_valid_o = valid_r;
	assign frame_pulse_o         = fp_r;
	assign recovery_active_o     = active_r;

	// Assertions on the block's own outputs and state.
	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	a_fp_width: assert property (
		$rose(fp_r) |-> fp_r [*8] ##1 !fp_r
	) else $error("frame pulse not one byte period wide");

	a_fp_cause: assert property (
		$rose(fp_r) |-> $past(word_is(word_r, FRAME_A2)) && $past(word_is(hist_r[0], FRAME_A2))
			&& $past(word_is(hist_r[1], FRAME_A1)) && $past(byte_stb)
	) else $error("frame pulse without a second A2 one byte earlier");

	a_fp_every: assert property (
		byte_stb && frame_hit |=> fp_r [*8]
	) else $error("aligned frame did not raise the frame pulse");

	a_fp_quiet: assert property (
		byte_stb && !frame_hit |=> !fp_r [*8]
	) else $error("frame pulse high without an aligned frame");

	a_hunt_start: assert property (
		hunt_fall && !recovery_inhibit_i |=> state_r == SFA_ST_HUNT ##1 recovery_active_o
	) else $error("trigger edge did not start recovery");

	a_hunt_inhibit: assert property (
		hunt_fall && recovery_inhibit_i |=> state_r == SFA_ST_IDLE ##1 !recovery_active_o
	) else $error("inhibited trigger edge did not stop recovery");

	a_align_phase: assert property (
		align_load |-> byte_stb ##1 (!byte_stb [*7]) ##1 byte_stb
	) else $error("byte phase not fixed at the A1 match");

	a_align_once: assert property (
		align_load |=> state_r == SFA_ST_TRACK ##0 !align_load
	) else $error("realignment repeated after the first A1");

	a_frame_stop: assert property (
		state_r == SFA_ST_TRACK && byte_stb && full_frame && !hunt_fall |=> state_r == SFA_ST_IDLE
	) else $error("recovery still active after a full framing sequence");

	a_valid_drop: assert property (
		hunt_fall |=> !parallel_data_valid_o
	) else $error("data still valid after trigger edge");

	a_byte_clock: assert property (
		$rose(byte_clock_out_o) |-> byte_clock_out_o [*4]
	) else $error("byte clock high phase shorter than half a byte");

	a_div_reach: assert property (
		byte_stb |-> ##[1:8] byte_stb
	) else $error("word boundary gap longer than one byte period");

	a_word_load: assert property (
		byte_stb |=> parallel_data_out_o == $past(shift_r)
	) else $error("parallel word not taken from the shift register");

	a_shift_order: assert property (
		1'b1 |=> shift_r[0] == $past(serial_data_in_i)
	) else $error("serial bit not shifted in at the low end");

	a_hist_shift: assert property (
		byte_stb |=> hist_r[0] == $past(word_r)
	) else $error("frame history lost the previous word");

	a_track_end: assert property (
		state_r == SFA_ST_TRACK && byte_stb && frame_hit && !hunt_fall |=> !recovery_active_o
	) else $error("aligned A1 A2 A2 did not end recovery");

	a_valid_rise: assert property (
		byte_stb && word_a1_to_a2 && !hunt_fall |=> parallel_data_valid_o
	) else $error("data not valid after the A1 to A2 change");

	a_active_state: assert property (
		recovery_active_o == (state_r != SFA_ST_IDLE)
	) else $error("recovery flag disagrees with the recovery state");

endmodule

//--- verification/sfa_ctrl_model.sv
`timescale 1ns/1ps
module sfa_ctrl_model (
	// Clock.
	input  wire logic clk_sys_i,
	// Frame control towards the device.
	output logic      trig_n_o,
	output logic      inhibit_o,
	// Frame status from the device.
	input  wire logic frame_pulse_i
);
	int   pulses;
	logic fp_q;

	// Idle with the trigger high, so that a later fall is a clean event.
	initial begin
		trig_n_o = 1'b1;
		inhibit_o = 1'b0;
		pulses = 0;
		fp_q = 1'b0;
	end

	// Count frame pulses on the falling edge, where the pulse has settled; a short count means sync is lost.
	always @(negedge clk_sys_i) begin
		if (frame_pulse_i && !fp_q) begin
			pulses++;
		end
		fp_q = frame_pulse_i;
	end

	// Pull the trigger low for two byte periods, with the inhibit set as asked.
	task automatic hunt(input logic inh);
		@(posedge clk_sys_i);
		inhibit_o <= inh;
		trig_n_o <= 1'b0;
		repeat (16) @(posedge clk_sys_i);
		trig_n_o <= 1'b1;
	endtask
endmodule

//--- verification/tb_sonet_frame_align_demux.sv
`timescale 1ns/1ps
module tb_sonet_frame_align_demux;
	import sfa_pkg::*;
	logic        clk_sys_i, resetn_i, serial_data_in_i, trig_n, inhibit;
	logic [7:0]  parallel_data_out_o;
	logic        byte_clock_out_o, parallel_data_valid_o, frame_pulse_o, recovery_active_o;
	logic [31:0] hist;
	logic [7:0]  notes[$];
	logic        fp_q, bc_q, vq;
	int          n_errors, checks, seed, cycles, frames, hi_cnt, gap;

	sfa_align_demux dut_u (
		.clk_sys_i             (clk_sys_i),
		.resetn_i              (resetn_i),
		.serial_data_in_i      (serial_data_in_i),
		.frame_hunt_trigger_n_i(trig_n),
		.recovery_inhibit_i    (inhibit),
		.parallel_data_out_o   (parallel_data_out_o),
		.byte_clock_out_o      (byte_clock_out_o),
		.parallel_data_valid_o (parallel_data_valid_o),
		.frame_pulse_o         (frame_pulse_o),
		.recovery_active_o     (recovery_active_o)
	);

	sfa_ctrl_model ctrl_u (
		.clk_sys_i    (clk_sys_i),
		.trig_n_o     (trig_n),
		.inhibit_o    (inhibit),
		.frame_pulse_i(frame_pulse_o)
	);

	// Bit clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Compare one value and count it.
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Print the verdict and stop.
	task automatic complete_run();
		if (n_errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Shift out the low n bits of b, first bit most significant.
	task automatic send_bits(input logic [7:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk_sys_i);
			serial_data_in_i <= b[i];
		end
	endtask

	// Filler bytes keep the top nibble clear, so they never imitate the pattern.
	task automatic fill(input int n);
		repeat (n) send_bits(8'($random(seed)) & 8'h0F, 8);
	endtask

	// A framing run of n pattern pairs; the byte after the second A2 is noted when a pulse is due.
	task automatic frame(input int n, input logic due);
		logic [7:0] nxt;
		nxt = 8'($random(seed)) & 8'h0F;
		fill(4);
		repeat (n) send_bits(FRAME_A1, 8);
		repeat (n) send_bits(FRAME_A2, 8);
		// At the pulse the outputs show the byte after the second A2: a third A2, or the byte after a short run.
		if (due) begin
			notes.push_back((n > 2) ? FRAME_A2 : nxt);
			frames++;
		end
		send_bits(nxt, 8);
		fill(3);
	endtask

	// Watch the parallel side on the falling edge, where the outputs have settled.
	always @(negedge clk_sys_i) begin
		gap++;
		if (byte_clock_out_o && !bc_q) begin
			hist = {hist[23:0], parallel_data_out_o};
			if (parallel_data_valid_o && vq) check(24'(gap), 24'h000008);
			vq = parallel_data_valid_o;
			gap = 0;
		end
		if (frame_pulse_o && !fp_q) begin
			if (notes.size() == 0) check(24'h000001, 24'h000000);
			else check(24'(parallel_data_out_o), 24'(notes.pop_front()));
			check(hist[31:8], {FRAME_A1, FRAME_A2, FRAME_A2});
			check(24'(parallel_data_valid_o), 24'h000001);
		end
		if (frame_pulse_o) begin
			hi_cnt++;
		end else if (fp_q) begin
			check(24'(hi_cnt), 24'h000008);
			check(24'(recovery_active_o), 24'h000000);
			hi_cnt = 0;
		end
		fp_q = frame_pulse_o;
		bc_q = byte_clock_out_o;
	end

	// Cut a hang short.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			complete_run();
		end
	end

	// Main sequence.
	initial begin
		seed = 79;
		{n_errors, checks, cycles, frames, hi_cnt, gap} = '0;
		{hist, fp_q, bc_q, vq} = '0;
		resetn_i = 1'b0;
		serial_data_in_i = 1'b0;
		repeat (20) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		send_bits(8'h00, 3);
		ctrl_u.hunt(1'b0);
		@(negedge clk_sys_i);
		check(24'(recovery_active_o), 24'h000001);
		check(24'(parallel_data_valid_o), 24'h000000);
		frame(3, 1'b1);
		frame(3, 1'b1);
		send_bits(8'h00, 5);
		ctrl_u.hunt(1'b0);
		frame(2, 1'b1);
		ctrl_u.hunt(1'b0);
		send_bits(FRAME_A1, 8);
		send_bits(8'h00, 3);
		frame(3, 1'b0);
		send_bits(8'h00, 5);
		frame(3, 1'b1);
		ctrl_u.hunt(1'b0);
		ctrl_u.hunt(1'b1);
		@(negedge clk_sys_i);
		check(24'(recovery_active_o), 24'h000000);
		send_bits(8'h00, 3);
		frame(3, 1'b0);
		check(24'(ctrl_u.pulses), 24'(frames));
		complete_run();
	end
endmodule
